// ### include/daf_pkg.sv
// Shared constants and carrier types for the distributed-arithmetic FIR.
// Assumes a single bit clock running at (data bits + 1) x the sample rate.

package daf_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int COEF_W = 8;
	localparam int TAPS = 16;
	localparam int HALF = TAPS / 2;
	localparam int ROM_IN = 4;
	localparam int CNT_W = 4;
	localparam int ACC_PAD = 4;
	localparam logic [CNT_W-1:0] CNT_FIRST = 4'h0;

	// ----------------------------------------------------------------
	// Default coefficients, C3 (lower word C7) in the top byte down to C0 (lower word C4)
	// ----------------------------------------------------------------
	localparam logic [ROM_IN*COEF_W-1:0] COEF_UP_DEF =
		{8'hfb, 8'h05, 8'hfc, 8'hfe};
	localparam logic [ROM_IN*COEF_W-1:0] COEF_LO_DEF =
		{8'h4e, 8'hee, 8'h03, 8'h03};

	// ----------------------------------------------------------------
	// Tag that travels with each bit-slice down the pipeline
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic uns;
		logic [CNT_W-1:0] slice;
	} daf_tag_t;

	localparam daf_tag_t TAG_IDLE = '0;

endpackage

// ### verilog/daf_fir16.sv
// Sixteen-tap linear-phase FIR filter using distributed arithmetic.
// Assumes the sample source holds sampleIn steady around sampleTake_q and
// that all inputs are synchronous to ref_clk, the bit clock.
// How it works
// - formatUnsigned high means unsigned, low two's-complement
// - Loader captures one sample each sample period
// - Loader shifts sample out one bit per clock
// - Bit clock is data bits plus one times sample rate
// - Skew buffer reads into holding flop, then writes
// - Held bit rewritten to next location, one tap on
// - Upper buffer taps 15:12, lower taps 11:4
// - Upper adder sums taps 3:0 with 15:12 serially
// - Lower adder sums taps 7:4 with 11:8 serially
// - Adder sums address coefficient ROMs, no multiply
// - ROM outputs added; complemented on sign slice
// - Accumulator loaded directly with first slice sum
// - Later slices add to halved previous total
// - Forced carry at adder and accumulator on sign
// - Output register holds result until next one
// - Four-bit counter decodes all control strobes
// - Two 16x8 ROMs hold coefficient subset sums
// - One computation takes nine bit clocks

`timescale 1ns/1ps

module daf_fir16 #(
	parameter int DATA_W = daf_pkg::DATA_W,
	parameter int COEF_W = daf_pkg::COEF_W,
	parameter logic [daf_pkg::ROM_IN*COEF_W-1:0] COEF_UPPER =
		daf_pkg::COEF_UP_DEF,
	parameter logic [daf_pkg::ROM_IN*COEF_W-1:0] COEF_LOWER =
		daf_pkg::COEF_LO_DEF,
	localparam int RES_W = DATA_W + COEF_W + daf_pkg::ACC_PAD
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic syncClear,
	input wire logic formatUnsigned,
	input wire logic [DATA_W-1:0] sampleIn,
	output logic sampleTake_q,
	output logic [RES_W-1:0] result_q,
	output logic resultValid_q
);

	// ----------------------------------------------------------------
	// Local geometry and elaboration check
	// ----------------------------------------------------------------
	localparam int CNT_W = daf_pkg::CNT_W;
	localparam int TAPS = daf_pkg::TAPS;
	localparam int HALF = daf_pkg::HALF;
	localparam int ROM_IN = daf_pkg::ROM_IN;
	localparam int PP_W = COEF_W + 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DATA_W);
	localparam logic [CNT_W-1:0] FIRST = daf_pkg::CNT_FIRST;

	// Counter must reach DATA_W, the overflow slice, in four bits
	if (DATA_W < 2 || DATA_W >= (1 << CNT_W) || COEF_W < 2) begin : gBad
		$error("daf_fir16: DATA_W or COEF_W out of range");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Subset sum of four coefficients; wraps to the ROM width
	function automatic logic [COEF_W-1:0] romWord(
		input logic [ROM_IN*COEF_W-1:0] coefs,
		input logic [ROM_IN-1:0] addr);
		logic [COEF_W-1:0] acc;
		acc = '0;
		for (int i = 0; i < ROM_IN; i++) begin
			if (addr[i]) begin
				acc = acc + coefs[i*COEF_W +: COEF_W];
			end
		end
		return acc;
	endfunction

	function automatic logic [PP_W-1:0] extWord(
		input logic [COEF_W-1:0] v);
		return {v[COEF_W-1], v};
	endfunction

	// ----------------------------------------------------------------
	// Sequencing counter
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic loadStrobe;

	always_comb begin
		cnt_d = (cnt_q == LAST) ? FIRST : cnt_q + 1'b1;
		loadStrobe = (cnt_q == LAST);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= FIRST;
			sampleTake_q <= 1'b0;
		end else if (clkEn) begin
			if (syncClear) begin
				cnt_q <= FIRST;
				sampleTake_q <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				sampleTake_q <= (cnt_d == LAST);
			end
		end
	end

	// ----------------------------------------------------------------
	// Parallel-to-serial loader
	// ----------------------------------------------------------------
	// Ninth bit is the overflow slice: sign copy or zero
	// Format rules a whole window: mixing formats within 16 taps is inexact
	logic [DATA_W:0] shreg_q;
	logic loadUns_q, loaded_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			shreg_q <= '0;
			loadUns_q <= 1'b0;
			loaded_q <= 1'b0;
		end else if (clkEn) begin
			if (syncClear) begin
				loaded_q <= 1'b0;
			end else if (loadStrobe) begin
				shreg_q <= {~formatUnsigned & sampleIn[DATA_W-1],
					sampleIn};
				loadUns_q <= formatUnsigned;
				loaded_q <= 1'b1;
			end else begin
				shreg_q <= {shreg_q[DATA_W], shreg_q[DATA_W:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Time-skew buffer
	// ----------------------------------------------------------------
	// Words 15:12 form the upper buffer, 11:4 the lower one, so
	// mirror taps leave the buffers in the same bit cycle.
	// Cleared at reset so early results carry no unknowns.
	logic [DATA_W:0] skewMem [1:TAPS-1];
	logic [TAPS-1:0] tapHold_q;
	daf_pkg::daf_tag_t tagHold_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 1; k < TAPS; k++) begin
				skewMem[k] <= '0;
			end
			tapHold_q <= '0;
			tagHold_q <= daf_pkg::TAG_IDLE;
		end else if (clkEn) begin
			tapHold_q[0] <= shreg_q[0];
			for (int k = 1; k < TAPS; k++) begin
				tapHold_q[k] <= skewMem[k][cnt_q];
			end
			skewMem[1][cnt_q] <= shreg_q[0];
			for (int k = 2; k < TAPS; k++) begin
				skewMem[k][cnt_q] <= skewMem[k-1][cnt_q];
			end
			if (syncClear) begin
				tagHold_q <= daf_pkg::TAG_IDLE;
			end else begin
				tagHold_q <= '{valid: loaded_q, uns: loadUns_q,
					slice: cnt_q};
			end
		end
	end

	// ----------------------------------------------------------------
	// Serial pair adders
	// ----------------------------------------------------------------
	// Bits 3:0 go to the upper ROM, bits 7:4 to the lower ROM
	logic [HALF-1:0] pairSum_q, carry_q;
	daf_pkg::daf_tag_t tagSum_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pairSum_q <= '0;
			carry_q <= '0;
			tagSum_q <= daf_pkg::TAG_IDLE;
		end else if (clkEn) begin
			if (syncClear) begin
				pairSum_q <= '0;
				carry_q <= '0;
				tagSum_q <= daf_pkg::TAG_IDLE;
			end else begin
				for (int p = 0; p < HALF; p++) begin
					// Carry restarts on the first slice of a sample
					{carry_q[p], pairSum_q[p]} <=
						2'(tapHold_q[p]) + 2'(tapHold_q[TAPS-1-p]) +
						2'((tagHold_q.slice != FIRST) & carry_q[p]);
				end
				tagSum_q <= tagHold_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Coefficient ROMs
	// ----------------------------------------------------------------
	logic [COEF_W-1:0] romUpper_q, romLower_q;
	daf_pkg::daf_tag_t tagRom_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			romUpper_q <= '0;
			romLower_q <= '0;
			tagRom_q <= daf_pkg::TAG_IDLE;
		end else if (clkEn) begin
			romUpper_q <= romWord(COEF_UPPER,
				pairSum_q[ROM_IN-1:0]);
			romLower_q <= romWord(COEF_LOWER,
				pairSum_q[HALF-1:ROM_IN]);
			tagRom_q <= syncClear ? daf_pkg::TAG_IDLE : tagSum_q;
		end
	end

	// ----------------------------------------------------------------
	// Partial-product adder
	// ----------------------------------------------------------------
	logic [PP_W-1:0] romUExt, romLExt, ppSum_q;
	logic romSign;
	daf_pkg::daf_tag_t tagPp_q;

	always_comb begin
		romUExt = extWord(romUpper_q);
		romLExt = extWord(romLower_q);
		romSign = (tagRom_q.slice == LAST) && !tagRom_q.uns;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ppSum_q <= '0;
			tagPp_q <= daf_pkg::TAG_IDLE;
		end else if (clkEn) begin
			if (romSign) begin
				ppSum_q <= PP_W'(~romUExt + ~romLExt + 1'b1);
			end else begin
				ppSum_q <= PP_W'(romUExt + romLExt);
			end
			tagPp_q <= syncClear ? daf_pkg::TAG_IDLE : tagRom_q;
		end
	end

	// ----------------------------------------------------------------
	// Scaling accumulator and output register
	// ----------------------------------------------------------------
	// Slices enter at weight 2^DATA_W and halve each step, so the
	// first slice reaches weight one with no low bits dropped.
	logic signed [RES_W-1:0] acc_q, accTerm, accNext;
	logic accSign;

	always_comb begin
		accSign = (tagPp_q.slice == LAST) && !tagPp_q.uns;
		accTerm = (RES_W'($signed(ppSum_q)) +
			RES_W'(accSign)) <<< DATA_W;
		if (tagPp_q.slice == FIRST) begin
			accNext = accTerm;
		end else begin
			accNext = (acc_q >>> 1) + accTerm;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc_q <= '0;
			result_q <= '0;
			resultValid_q <= 1'b0;
		end else if (clkEn) begin
			if (syncClear) begin
				acc_q <= '0;
				result_q <= '0;
				resultValid_q <= 1'b0;
			end else begin
				acc_q <= accNext;
				resultValid_q <= tagPp_q.valid &&
					(tagPp_q.slice == LAST);
				if (tagPp_q.valid && tagPp_q.slice == LAST) begin
					result_q <= accNext;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Clocked on enabled edges only, since a low clkEn freezes all
	default clocking dafCk @(posedge ref_clk iff clkEn);
	endclocking
	default disable iff (!resetn || syncClear);
	sequence takeThenShift;
		loadStrobe ##1 (cnt_q == FIRST);
	endsequence
	sequence quietGap;
		!resultValid_q [*8];
	endsequence
	cnt_wrap_a: assert property (
		loadStrobe |=> cnt_q == FIRST)
		else $error("Counter did not wrap after overflow slice");
	take_strobe_a: assert property (
		sampleTake_q |-> loadStrobe)
		else $error("Take strobe out of step with counter");
	load_sample_a: assert property (
		takeThenShift |-> shreg_q[DATA_W-1:0] == $past(sampleIn))
		else $error("Loader did not capture sample");
	format_ext_a: assert property (
		loadStrobe |=> shreg_q[DATA_W] ==
			(!$past(formatUnsigned) && $past(sampleIn[DATA_W-1])))
		else $error("Overflow bit ignores number format");
	serial_shift_a: assert property (
		!loadStrobe |=> shreg_q[DATA_W-1:0] == $past(shreg_q[DATA_W:1]))
		else $error("Loader did not shift one bit");
	tap_advance_a: assert property (
		tagHold_q.valid && $past(tagHold_q.valid, 9) |->
			tapHold_q[1] == $past(tapHold_q[0], 9))
		else $error("Delay line did not advance one tap");
	sign_pp_a: assert property (
		romSign |=> PP_W'(ppSum_q + $past(romUExt) + $past(romLExt)
			+ 1'b1) == '0)
		else $error("Sign slice not complemented with carry");
	acc_load_a: assert property (
		tagPp_q.slice == FIRST |=>
			acc_q == (RES_W'($signed($past(ppSum_q))) <<< DATA_W))
		else $error("Accumulator not loaded with first slice");
	valid_pulse_a: assert property (
		resultValid_q |=> quietGap ##1 resultValid_q)
		else $error("Valid pulse not one in nine cycles");
	result_hold_a: assert property (
		resultValid_q |=> $stable(result_q) [*8])
		else $error("Result changed before next capture");

endmodule

// ### bench/daf_stream_partner.sv
// Behavioural sample source and result sink for the DA FIR filter.
// Assumes its outputs may change 1 ns after the rising edge of ref_clk.

`timescale 1ns/1ps

module daf_stream_partner #(
	parameter int RW = daf_pkg::DATA_W + daf_pkg::COEF_W + daf_pkg::ACC_PAD
) (
	input wire logic ref_clk,
	input wire logic clkEn,
	input wire logic sampleTake_q,
	input wire logic resultValid_q,
	input wire logic [RW-1:0] result_q,
	output logic [daf_pkg::DATA_W-1:0] sampleIn,
	output logic formatUnsigned
);
	// Queued samples are {format, value}
	logic [8:0] pend[$];
	logic [8:0] sent[$];
	logic [RW-1:0] got[$];
	logic [8:0] cur;
	logic showing;

	initial begin
		sampleIn = 8'h00;
		formatUnsigned = 1'b0;
		showing = 1'b0;
		cur = 9'h000;
	end

	// One sample per take pulse, consumed at the enabled edge
	always @(posedge ref_clk) begin
		if (clkEn && sampleTake_q === 1'b1 && showing) begin
			sent.push_back(cur);
			showing = 1'b0;
		end
		if (clkEn && resultValid_q === 1'b1)
			got.push_back(result_q);
		#1;
		if (sampleTake_q === 1'b1 && !showing) begin
			cur = (pend.size() > 0) ? pend.pop_front() : 9'h000;
			showing = 1'b1;
		end
		// Lines are not held outside the take: a late capture shows up
		{formatUnsigned, sampleIn} = showing ? cur : ~{formatUnsigned, sampleIn};
	end
endmodule

// ### bench/distributed_arith_fir16_bench.sv
// Self-checking bench for the distributed-arithmetic FIR filter.
// Assumes the partner model supplies samples and records every result.

`timescale 1ns/1ps

module distributed_arith_fir16_bench;
	localparam int RW = daf_pkg::DATA_W + daf_pkg::COEF_W + daf_pkg::ACC_PAD;
	logic ref_clk, resetn, clkEn, syncClear, formatUnsigned;
	logic [7:0] sampleIn;
	logic sampleTake_q, resultValid_q;
	logic [RW-1:0] result_q, lastRes;
	int bad_count = 0, n_checks = 0, encyc = 0, lastV = 0, np = 0;
	bit monOn = 0;

	daf_fir16 i_daf_fir16 (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.syncClear(syncClear),
		.formatUnsigned(formatUnsigned),
		.sampleIn(sampleIn),
		.sampleTake_q(sampleTake_q),
		.result_q(result_q),
		.resultValid_q(resultValid_q)
	);

	daf_stream_partner i_daf_stream_partner (
		.ref_clk(ref_clk),
		.clkEn(clkEn),
		.sampleTake_q(sampleTake_q),
		.resultValid_q(resultValid_q),
		.result_q(result_q),
		.sampleIn(sampleIn),
		.formatUnsigned(formatUnsigned)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// Reference arithmetic
	// ----------------------------------------------------------------
	function automatic int val(logic [8:0] s);
		return s[8] ? int'(s[7:0]) : int'($signed(s[7:0]));
	endfunction

	function automatic int cof(int k);
		int i;
		i = (k < 8) ? k : 15 - k;
		if (i < 4)
			return int'($signed(daf_pkg::COEF_UP_DEF[i*8+:8]));
		return int'($signed(daf_pkg::COEF_LO_DEF[(i-4)*8+:8]));
	endfunction

	// Index the next queued sample will have among the sent ones; fillers
	// sent while the queue ran dry are counted too
	function automatic int next_idx();
		return i_daf_stream_partner.sent.size() +
			i_daf_stream_partner.pend.size() +
			int'(i_daf_stream_partner.showing);
	endfunction

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(logic [RW-1:0] a, logic [RW-1:0] b, string m);
		n_checks++;
		if (a !== b) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, a, b);
		end
	endtask

	task automatic first_take();
		int n;
		n = 0;
		while (sampleTake_q !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(n, 8, "first take edge");
	endtask

	// Queues restart so that history is taken as zero after a reset
	task automatic restart();
		i_daf_stream_partner.pend.delete();
		i_daf_stream_partner.sent.delete();
		i_daf_stream_partner.got.delete();
		np = 0;
		lastV = 0;
		lastRes = '0;
		monOn = 1;
	endtask

	task automatic reset_dut();
		#1;
		monOn = 0;
		resetn = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		restart();
		first_take();
	endtask

	task automatic push(logic [7:0] v, logic f);
		i_daf_stream_partner.pend.push_back({f, v});
		np = next_idx();
	endtask

	// Waits for all pushed results and compares from index first on
	task automatic settle(int first);
		int y;
		for (int w = 0; w < 3000 && i_daf_stream_partner.got.size() < np; w++)
			@(posedge ref_clk);
		#1;
		check(i_daf_stream_partner.got.size() >= np, 1, "count");
		for (int j = first; j < np; j++) begin
			y = 0;
			for (int k = 0; k < 16 && k <= j; k++)
				y += cof(k) * val(i_daf_stream_partner.sent[j - k]);
			check(i_daf_stream_partner.got[j], y[RW-1:0], "fir");
		end
	endtask

	// Strobe spacing and result hold between strobes
	always @(posedge ref_clk) begin
		if (clkEn && monOn) begin
			encyc++;
			if (resultValid_q === 1'b1) begin
				if (lastV > 0)
					check(encyc - lastV, 9, "valid spacing");
				lastV = encyc;
				lastRes = result_q;
			end else
				check(result_q, lastRes, "result hold");
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_impulse(logic [7:0] v);
		push(v, 1'b0);
		repeat (16) push(8'h00, 1'b0);
		settle(0);
	endtask

	task automatic t_formats();
		logic [7:0] pat[6] = '{8'h80, 8'h7f, 8'hff, 8'h01, 8'h80, 8'hff};
		int s;
		s = next_idx();
		foreach (pat[i]) push(pat[i], 1'b0);
		// The sign slice is decided per result, so older samples of the
		// other format must have left all 16 taps first
		repeat (15) push(8'h00, 1'b0);
		foreach (pat[i]) push(pat[i], 1'b1);
		repeat (15) push(8'h00, 1'b1);
		// Toggling format per sample is exact only below half range
		foreach (pat[i]) push(pat[i] & 8'h7f, 1'(i));
		settle(s);
	endtask

	task automatic t_freeze();
		logic [RW-1:0] r;
		int s;
		s = next_idx();
		repeat (10) push(8'h93, 1'b0);
		repeat (25) @(posedge ref_clk);
		#1;
		clkEn = 1'b0;
		r = result_q;
		repeat (15) @(posedge ref_clk);
		#1;
		check(result_q, r, "frozen result");
		clkEn = 1'b1;
		settle(s);
	endtask

	task automatic t_clear();
		repeat (8) push(8'h5a, 1'b1);
		repeat (31) @(posedge ref_clk);
		#1;
		monOn = 0;
		syncClear = 1'b1;
		@(posedge ref_clk);
		#1;
		syncClear = 1'b0;
		check({sampleTake_q, resultValid_q}, 0, "clear strobes");
		check(result_q, 0, "clear result");
		restart();
		first_take();
		repeat (20) push(8'hc4, 1'b0);
		settle(15);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and verdict
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end

	initial begin
		resetn = 1'b0;
		clkEn = 1'b1;
		syncClear = 1'b0;
		reset_dut();
		t_impulse(8'h01);
		t_formats();
		t_freeze();
		t_clear();
		repeat (5) push(8'h33, 1'b0);
		repeat (20) @(posedge ref_clk);
		reset_dut();
		t_impulse(8'h7f);
		print_verdict();
	end
endmodule
